// ---- rtl/cmf_core.sv ----
`timescale 1ns/1ps
`include "cmf_regs.svh"
module cmf_core
    import cmf_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic issue,
    input wire cmf_op_t op,
    input wire logic [7:0] rd_val,
    input wire logic [7:0] rr_val,
    input wire logic [7:0] imm,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] io_val,
    input wire logic [11:0] rel_offset,
    input wire logic [6:0] br_offset,
    input wire logic [15:0] abs_addr,
    input wire logic [15:0] z_ptr,
    input wire logic [15:0] stack_pc,
    input wire logic next_two_word,
    output logic ready,
    output logic [15:0] pc_q,
    output logic [7:0] status_register_q,
    output logic rd_we_q,
    output logic [7:0] rd_wdata_q,
    output logic prod_we_q,
    output logic [15:0] prod_q,
    output logic push_pc_q,
    output logic pop_pc_q
);
    // ------------------------------------------------------------
    // Decode and single-cycle datapath
    // ------------------------------------------------------------
    cmf_state_t state_q;
    logic [2:0] cnt_q;
    logic [15:0] target_q;
    logic is_mul;
    logic [8:0] sub_res;
    logic [4:0] sub_lo;
    logic [7:0] alu_res;
    logic flag_bit;
    logic br_take;
    logic skip_take;
    logic [2:0] cycles;
    logic [15:0] next_pc;
    logic [15:0] seq_pc;
    logic [15:0] skip_pc;
    logic [15:0] br_pc;
    logic [15:0] rel_pc;
    logic mul_done;
    logic mul_carry;
    logic mul_zero;
    logic [15:0] mul_prod;
    logic wr_zn;
    logic wr_arith;
    logic v_res;

    assign is_mul = (op >= CMF_OP_MULTIPLY_UNSIGNED)
                  && (op <= CMF_OP_FRACTIONAL_MULTIPLY_MIXED);
    assign seq_pc = pc_q + 16'h0001;
    assign skip_pc = pc_q + (next_two_word ? 16'h0003 : 16'h0002);
    assign rel_pc = pc_q + {{4{rel_offset[11]}}, rel_offset} + 16'h0001;
    assign br_pc = pc_q + {{9{br_offset[6]}}, br_offset} + 16'h0001;

    // Compare subtract with optional carry-in, and half-borrow
    always_comb begin
        logic [7:0] rhs;
        logic cin;
        rhs = (op == CMF_OP_COMPARE_IMMEDIATE) ? imm : rr_val;
        cin = (op == CMF_OP_COMPARE_WITH_CARRY) ? status_register_q[`CMF_FLAG_C] : 1'b0;
        sub_res = {1'b0, rd_val} - {1'b0, rhs} - {8'h00, cin};
        sub_lo = {1'b0, rd_val[3:0]} - {1'b0, rhs[3:0]} - {4'h0, cin}; // Borrow out of bit 3
        if (op == CMF_OP_COMPARE_IMMEDIATE || op == CMF_OP_COMPARE ||
            op == CMF_OP_COMPARE_WITH_CARRY) begin
            v_res = (rd_val[7] ^ rhs[7]) & (rd_val[7] ^ sub_res[7]);
        end else if (op == CMF_OP_DECREMENT_REGISTER) begin
            v_res = (rd_val == 8'h80);
        end else begin
            v_res = 1'b0;
        end
    end

    // Result of the one-register arithmetic group
    always_comb begin
        unique case (op)
            CMF_OP_TEST_REGISTER: alu_res = rd_val & rd_val;
            CMF_OP_DECREMENT_REGISTER: alu_res = rd_val - 8'h01;
            CMF_OP_CLEAR_REGISTER: alu_res = rd_val ^ rd_val;
            CMF_OP_SET_REGISTER_ALL_ONES: alu_res = 8'hff;
            default: alu_res = sub_res[7:0];
        endcase
    end

    // Condition selection; named branches are flag-select aliases
    assign flag_bit = status_register_q[bit_sel];
    always_comb begin
        br_take = 1'b0;
        skip_take = 1'b0;
        if (op == CMF_OP_BRANCH_FLAG_SET) begin
            br_take = (bit_sel == `CMF_FLAG_S)
                ? (status_register_q[`CMF_FLAG_N] ^ status_register_q[`CMF_FLAG_V])
                : flag_bit;
        end else if (op == CMF_OP_BRANCH_FLAG_CLEAR) begin
            br_take = (bit_sel == `CMF_FLAG_S)
                ? ~(status_register_q[`CMF_FLAG_N] ^ status_register_q[`CMF_FLAG_V])
                : ~flag_bit;
        end else if (op == CMF_OP_COMPARE_SKIP_EQUAL) begin
            skip_take = (rd_val == rr_val);
        end else if (op == CMF_OP_SKIP_REG_BIT_CLEAR) begin
            skip_take = ~rr_val[bit_sel];
        end else if (op == CMF_OP_SKIP_REG_BIT_SET) begin
            skip_take = rr_val[bit_sel];
        end else if (op == CMF_OP_SKIP_IO_BIT_CLEAR) begin
            skip_take = ~io_val[bit_sel];
        end else if (op == CMF_OP_SKIP_IO_BIT_SET) begin
            skip_take = io_val[bit_sel];
        end
    end

    // Target PC and clock count per instruction
    always_comb begin
        next_pc = seq_pc;
        cycles = `CMF_CYC_ONE;
        unique case (op)
            CMF_OP_MULTIPLY_UNSIGNED, CMF_OP_MULTIPLY_SIGNED,
            CMF_OP_MULTIPLY_SIGNED_BY_UNSIGNED, CMF_OP_FRACTIONAL_MULTIPLY_UNSIGNED,
            CMF_OP_FRACTIONAL_MULTIPLY_SIGNED, CMF_OP_FRACTIONAL_MULTIPLY_MIXED: begin
                cycles = `CMF_CYC_TWO;
            end
            CMF_OP_RELATIVE_JUMP: begin
                next_pc = rel_pc;
                cycles = `CMF_CYC_TWO;
            end
            CMF_OP_RELATIVE_CALL: begin
                next_pc = rel_pc;
                cycles = `CMF_CYC_THREE;
            end
            CMF_OP_POINTER_JUMP: begin
                next_pc = z_ptr;
                cycles = `CMF_CYC_TWO;
            end
            CMF_OP_POINTER_CALL: begin
                next_pc = z_ptr;
                cycles = `CMF_CYC_THREE;
            end
            CMF_OP_ABSOLUTE_JUMP: begin
                next_pc = abs_addr;
                cycles = `CMF_CYC_THREE;
            end
            CMF_OP_ABSOLUTE_CALL: begin
                next_pc = abs_addr;
                cycles = `CMF_CYC_FOUR;
            end
            CMF_OP_SUBROUTINE_RETURN, CMF_OP_INTERRUPT_RETURN: begin
                next_pc = stack_pc;
                cycles = `CMF_CYC_FOUR;
            end
            CMF_OP_BRANCH_FLAG_SET, CMF_OP_BRANCH_FLAG_CLEAR: begin
                if (br_take) begin
                    next_pc = br_pc;
                    cycles = `CMF_CYC_TWO;
                end
            end
            CMF_OP_COMPARE_SKIP_EQUAL, CMF_OP_SKIP_REG_BIT_CLEAR,
            CMF_OP_SKIP_REG_BIT_SET, CMF_OP_SKIP_IO_BIT_CLEAR,
            CMF_OP_SKIP_IO_BIT_SET: begin
                if (skip_take) begin
                    next_pc = skip_pc;
                    cycles = next_two_word ? `CMF_CYC_THREE : `CMF_CYC_TWO;
                end
            end
            default: begin
                next_pc = seq_pc;
                cycles = `CMF_CYC_ONE;
            end
        endcase
    end

    // Flag write enables: set-all-ones and flow instructions other than interrupt return touch none
    assign wr_zn = (op == CMF_OP_TEST_REGISTER) || (op == CMF_OP_DECREMENT_REGISTER)
                || (op == CMF_OP_CLEAR_REGISTER) || wr_arith;
    assign wr_arith = (op == CMF_OP_COMPARE) || (op == CMF_OP_COMPARE_WITH_CARRY)
                   || (op == CMF_OP_COMPARE_IMMEDIATE);

    // ------------------------------------------------------------
    // Multiplier and sequencing
    // ------------------------------------------------------------
    cmf_mult #(
        .WIDTH(8)
    ) u_mult (
        .core_clk(core_clk),
        .rst(rst),
        .start(issue && ready && is_mul),
        .op_a(rd_val),
        .op_b(rr_val),
        .a_signed(op != CMF_OP_MULTIPLY_UNSIGNED && op != CMF_OP_FRACTIONAL_MULTIPLY_UNSIGNED),
        .b_signed(op == CMF_OP_MULTIPLY_SIGNED || op == CMF_OP_FRACTIONAL_MULTIPLY_SIGNED),
        .frac(op >= CMF_OP_FRACTIONAL_MULTIPLY_UNSIGNED),
        .product_q(mul_prod),
        .carry_q(mul_carry),
        .zero_q(mul_zero),
        .done_q(mul_done)
    );

    assign ready = (state_q == CMF_ST_IDLE);

    // Multi-clock instructions hold off issue for their extra clocks
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= CMF_ST_IDLE;
            cnt_q <= 3'd0;
        end else begin
            unique case (state_q)
                CMF_ST_IDLE: begin
                    if (issue && cycles > `CMF_CYC_ONE) begin
                        state_q <= CMF_ST_BUSY;
                        cnt_q <= cycles - 3'd1;
                    end
                end
                CMF_ST_BUSY: begin
                    cnt_q <= cnt_q - 3'd1;
                    if (cnt_q == 3'd2 || cnt_q == 3'd1) begin
                        state_q <= (cnt_q == 3'd1) ? CMF_ST_IDLE : CMF_ST_DONE;
                    end
                end
                CMF_ST_DONE: begin
                    state_q <= CMF_ST_IDLE;
                    cnt_q <= 3'd0;
                end
                default: begin
                    state_q <= CMF_ST_IDLE;
                    cnt_q <= 3'd0;
                end
            endcase
        end
    end

    // PC commits at the last clock so the target is seen when ready returns
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pc_q <= `CMF_PC_RST;
            target_q <= `CMF_PC_RST;
        end else if (issue && ready) begin
            if (cycles == `CMF_CYC_ONE) begin
                pc_q <= next_pc;
            end else begin
                target_q <= next_pc;
            end
        end else if (!ready && (state_q == CMF_ST_DONE || cnt_q == 3'd1)) begin
            pc_q <= target_q;
        end
    end

    // Call pushes at issue, returns pop at issue
    always_ff @(posedge core_clk) begin
        if (rst) begin
            push_pc_q <= 1'b0;
            pop_pc_q <= 1'b0;
        end else begin
            push_pc_q <= issue && ready && (op == CMF_OP_RELATIVE_CALL
                || op == CMF_OP_POINTER_CALL || op == CMF_OP_ABSOLUTE_CALL);
            pop_pc_q <= issue && ready && (op == CMF_OP_SUBROUTINE_RETURN
                || op == CMF_OP_INTERRUPT_RETURN);
        end
    end

    // Register writeback; test and compares never write back
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_we_q <= 1'b0;
            rd_wdata_q <= 8'h00;
            prod_we_q <= 1'b0;
            prod_q <= 16'h0000;
        end else begin
            rd_we_q <= issue && ready && (op == CMF_OP_DECREMENT_REGISTER
                || op == CMF_OP_CLEAR_REGISTER || op == CMF_OP_SET_REGISTER_ALL_ONES);
            rd_wdata_q <= alu_res;
            prod_we_q <= mul_done;
            if (mul_done) begin
                prod_q <= mul_prod;
            end
        end
    end

    // Status register; interrupt return also sets the global enable
    always_ff @(posedge core_clk) begin
        if (rst) begin
            status_register_q <= `CMF_STATUS_REGISTER_RST;
        end else if (mul_done) begin
            status_register_q[`CMF_FLAG_Z] <= mul_zero;
            status_register_q[`CMF_FLAG_C] <= mul_carry;
        end else if (issue && ready) begin
            if (wr_zn) begin
                status_register_q[`CMF_FLAG_Z] <= (alu_res == 8'h00)
                    & (op != CMF_OP_COMPARE_WITH_CARRY | status_register_q[`CMF_FLAG_Z]);
                status_register_q[`CMF_FLAG_N] <= alu_res[7];
                status_register_q[`CMF_FLAG_V] <= v_res;
                status_register_q[`CMF_FLAG_S] <= alu_res[7] ^ v_res;
            end
            if (wr_arith) begin
                status_register_q[`CMF_FLAG_C] <= sub_res[8];
                status_register_q[`CMF_FLAG_H] <= sub_lo[4];
            end
            if (op == CMF_OP_INTERRUPT_RETURN) begin
                status_register_q[`CMF_FLAG_I] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_mul_two_clk: assert property (@(posedge core_clk) disable iff (rst)
        (issue && ready && is_mul) |-> ##2 prod_we_q) else $error("multiply not done in 2");
    a_frac_shift: assert property (@(posedge core_clk) disable iff (rst)
        prod_we_q && $past(op, 2) >= CMF_OP_FRACTIONAL_MULTIPLY_UNSIGNED
        && $past(issue, 2) |-> !prod_q[0]) else $error("fractional lsb not zero");
    a_relative_jump_busy: assert property (@(posedge core_clk) disable iff (rst)
        (issue && ready && op == CMF_OP_RELATIVE_JUMP) |=> !ready ##1 ready)
        else $error("relative jump not two clocks");
    a_call_three: assert property (@(posedge core_clk) disable iff (rst)
        (issue && ready && op == CMF_OP_POINTER_CALL) |=> !ready [*2] ##1 ready)
        else $error("pointer call not three clocks");
    a_ret_four: assert property (@(posedge core_clk) disable iff (rst)
        (issue && ready && op == CMF_OP_SUBROUTINE_RETURN) |=> !ready [*3] ##1 ready)
        else $error("return not four clocks");
    a_test_nowrite: assert property (@(posedge core_clk) disable iff (rst)
        (issue && ready && op == CMF_OP_TEST_REGISTER) |=> !rd_we_q && ready)
        else $error("test wrote register");
    a_branch_miss: assert property (@(posedge core_clk) disable iff (rst)
        (issue && ready && op == CMF_OP_BRANCH_FLAG_SET && !br_take)
        |=> pc_q == $past(pc_q) + 16'h0001) else $error("untaken branch pc wrong");
    a_ser_flags: assert property (@(posedge core_clk) disable iff (rst)
        (issue && ready && op == CMF_OP_SET_REGISTER_ALL_ONES && !mul_done)
        |=> status_register_q == $past(status_register_q) && rd_wdata_q == 8'hff)
        else $error("set register touched flags");
endmodule

// ---- shared/cmf_regs.svh ----
`ifndef CMF_REGS_SVH
`define CMF_REGS_SVH
// Status register bit positions
`define CMF_FLAG_C 3'd0
`define CMF_FLAG_Z 3'd1
`define CMF_FLAG_N 3'd2
`define CMF_FLAG_V 3'd3
`define CMF_FLAG_S 3'd4
`define CMF_FLAG_H 3'd5
`define CMF_FLAG_T 3'd6
`define CMF_FLAG_I 3'd7
// Cycle counts per instruction class
`define CMF_CYC_ONE 3'd1
`define CMF_CYC_TWO 3'd2
`define CMF_CYC_THREE 3'd3
`define CMF_CYC_FOUR 3'd4
// Reset values
`define CMF_PC_RST 16'h0000
`define CMF_STATUS_REGISTER_RST 8'h00
`endif

// ---- shared/cmf_pkg.sv ----
package cmf_pkg;
    typedef enum logic [5:0] {
        CMF_OP_NOP = 6'h00,
        CMF_OP_TEST_REGISTER = 6'h01,
        CMF_OP_DECREMENT_REGISTER = 6'h02,
        CMF_OP_CLEAR_REGISTER = 6'h03,
        CMF_OP_SET_REGISTER_ALL_ONES = 6'h04,
        CMF_OP_MULTIPLY_UNSIGNED = 6'h05,
        CMF_OP_MULTIPLY_SIGNED = 6'h06,
        CMF_OP_MULTIPLY_SIGNED_BY_UNSIGNED = 6'h07,
        CMF_OP_FRACTIONAL_MULTIPLY_UNSIGNED = 6'h08,
        CMF_OP_FRACTIONAL_MULTIPLY_SIGNED = 6'h09,
        CMF_OP_FRACTIONAL_MULTIPLY_MIXED = 6'h0a,
        CMF_OP_RELATIVE_JUMP = 6'h0b,
        CMF_OP_RELATIVE_CALL = 6'h0c,
        CMF_OP_POINTER_JUMP = 6'h0d,
        CMF_OP_POINTER_CALL = 6'h0e,
        CMF_OP_ABSOLUTE_JUMP = 6'h0f,
        CMF_OP_ABSOLUTE_CALL = 6'h10,
        CMF_OP_SUBROUTINE_RETURN = 6'h11,
        CMF_OP_INTERRUPT_RETURN = 6'h12,
        CMF_OP_COMPARE_SKIP_EQUAL = 6'h13,
        CMF_OP_COMPARE = 6'h14,
        CMF_OP_COMPARE_WITH_CARRY = 6'h15,
        CMF_OP_COMPARE_IMMEDIATE = 6'h16,
        CMF_OP_SKIP_REG_BIT_CLEAR = 6'h17,
        CMF_OP_SKIP_REG_BIT_SET = 6'h18,
        CMF_OP_SKIP_IO_BIT_CLEAR = 6'h19,
        CMF_OP_SKIP_IO_BIT_SET = 6'h1a,
        CMF_OP_BRANCH_FLAG_SET = 6'h1b,
        CMF_OP_BRANCH_FLAG_CLEAR = 6'h1c
    } cmf_op_t;

    typedef enum logic [2:0] {
        CMF_ST_IDLE = 3'b001,
        CMF_ST_BUSY = 3'b010,
        CMF_ST_DONE = 3'b100
    } cmf_state_t;
endpackage

// ---- rtl/cmf_mult.sv ----
`timescale 1ns/1ps
`include "cmf_regs.svh"
// 8x8 multiplier with sign selects and fractional shift
module cmf_mult
    import cmf_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [WIDTH-1:0] op_a,
    input wire logic [WIDTH-1:0] op_b,
    input wire logic a_signed,
    input wire logic b_signed,
    input wire logic frac,
    output logic [2*WIDTH-1:0] product_q,
    output logic carry_q,
    output logic zero_q,
    output logic done_q
);
    logic signed [2*WIDTH+1:0] full_d;
    logic [2*WIDTH-1:0] raw_d;

    // Sign extend each operand by its own select
    always_comb begin
        full_d = $signed({a_signed & op_a[WIDTH-1], op_a})
               * $signed({b_signed & op_b[WIDTH-1], op_b});
        raw_d = full_d[2*WIDTH-1:0];
    end

    // Registered at the issue edge so the core writes back on the next, inside two clocks;
    // carry is bit 15 before the shift, zero after it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            product_q <= '0;
            carry_q <= 1'b0;
            zero_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= start;
            if (start) begin
                carry_q <= raw_d[2*WIDTH-1];
                product_q <= frac ? {raw_d[2*WIDTH-2:0], 1'b0} : raw_d;
                zero_q <= frac ? (raw_d[2*WIDTH-2:0] == '0) : (raw_d == '0);
            end
        end
    end
endmodule

// ---- tb/tb_cpu_multiply_and_flow_control.sv ----
`timescale 1ns/1ps
`include "cmf_regs.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb_cpu_multiply_and_flow_control import cmf_pkg::*; ;
    // ----------------------------------------
    // Stimulus, outputs and model state
    // ----------------------------------------
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic issue = 1'b0;
    cmf_op_t op = CMF_OP_NOP;
    logic [7:0] rd_val = 8'h00, rr_val = 8'h00, imm = 8'h00, io_val = 8'h00;
    logic [2:0] bit_sel = 3'h0;
    logic [11:0] rel_offset = 12'h000;
    logic [6:0] br_offset = 7'h00;
    logic [15:0] abs_addr = 16'h0000, z_ptr = 16'h0000, stack_pc = 16'h0000;
    logic next_two_word = 1'b0;
    logic ready, rd_we_q, prod_we_q, push_pc_q, pop_pc_q;
    logic [15:0] pc_q, prod_q;
    logic [7:0] status_register_q, rd_wdata_q;
    logic [15:0] m_pc, e_pc, e_prod;
    logic [7:0] m_sr, e_sr, e_rdw;
    logic e_rdwe, e_pwe, e_push, e_pop;
    int e_cyc, errors = 0, check_count = 0, cyc_cnt = 0;
    localparam int LIMIT = 20000; // Far above ~600 ops of at most four cycles

    cmf_core i_dut (.core_clk(core_clk), .rst(rst), .issue(issue), .op(op), .rd_val(rd_val),
        .rr_val(rr_val), .imm(imm), .bit_sel(bit_sel), .io_val(io_val),
        .rel_offset(rel_offset), .br_offset(br_offset), .abs_addr(abs_addr), .z_ptr(z_ptr),
        .stack_pc(stack_pc), .next_two_word(next_two_word), .ready(ready), .pc_q(pc_q),
        .status_register_q(status_register_q), .rd_we_q(rd_we_q), .rd_wdata_q(rd_wdata_q),
        .prod_we_q(prod_we_q), .prod_q(prod_q), .push_pc_q(push_pc_q), .pop_pc_q(pop_pc_q));

    // 100 MHz clock and hang guard
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc_cnt++;
        if (cyc_cnt == LIMIT) begin
            errors++;
            wrap_up();
        end
    end

    // ----------------------------------------
    // Reference model of one instruction
    // ----------------------------------------
    function automatic void predict();
        logic [8:0] d;
        logic [7:0] b;
        logic signed [17:0] pw;
        logic [15:0] p;
        logic sk, tk, as, bs, fr, sel;
        begin
            e_sr = m_sr;
            e_pc = m_pc + 16'h0001;
            e_cyc = 1;
            {e_rdwe, e_pwe, e_push, e_pop, sk, tk} = 6'h00;
            e_rdw = 8'h00;
            e_prod = 16'h0000;
            b = (op == CMF_OP_COMPARE_IMMEDIATE) ? imm : rr_val;
            d = {1'b0, rd_val} - {1'b0, b} - {8'h00, op == CMF_OP_COMPARE_WITH_CARRY && m_sr[0]};
            as = op inside {CMF_OP_MULTIPLY_SIGNED, CMF_OP_MULTIPLY_SIGNED_BY_UNSIGNED,
                CMF_OP_FRACTIONAL_MULTIPLY_SIGNED, CMF_OP_FRACTIONAL_MULTIPLY_MIXED};
            bs = op inside {CMF_OP_MULTIPLY_SIGNED, CMF_OP_FRACTIONAL_MULTIPLY_SIGNED};
            fr = op inside {CMF_OP_FRACTIONAL_MULTIPLY_UNSIGNED,
                CMF_OP_FRACTIONAL_MULTIPLY_SIGNED, CMF_OP_FRACTIONAL_MULTIPLY_MIXED};
            // Signed status bit slot stands for N xor V
            sel = (bit_sel == 3'd4) ? (m_sr[2] ^ m_sr[3]) : m_sr[bit_sel];
            case (op)
                CMF_OP_TEST_REGISTER: e_sr[3:1] = {1'b0, rd_val[7], rd_val == 8'h00};
                CMF_OP_DECREMENT_REGISTER: begin
                    e_rdwe = 1'b1;
                    e_rdw = rd_val - 8'h01;
                    e_sr[3:1] = {rd_val == 8'h80, e_rdw[7], e_rdw == 8'h00};
                end
                CMF_OP_CLEAR_REGISTER: begin
                    e_rdwe = 1'b1;
                    e_sr[3:1] = 3'b001;
                end
                CMF_OP_SET_REGISTER_ALL_ONES: begin
                    e_rdwe = 1'b1;
                    e_rdw = 8'hff;
                end
                CMF_OP_MULTIPLY_UNSIGNED, CMF_OP_MULTIPLY_SIGNED,
                CMF_OP_MULTIPLY_SIGNED_BY_UNSIGNED, CMF_OP_FRACTIONAL_MULTIPLY_UNSIGNED,
                CMF_OP_FRACTIONAL_MULTIPLY_SIGNED, CMF_OP_FRACTIONAL_MULTIPLY_MIXED: begin
                    pw = $signed({as & rd_val[7], rd_val}) * $signed({bs & rr_val[7], rr_val});
                    p = pw[15:0];
                    e_sr[0] = p[15]; // Carry from the unshifted product
                    if (fr) begin
                        p = p << 1;
                    end
                    e_sr[1] = (p == 16'h0000);
                    {e_pwe, e_prod, e_cyc} = {1'b1, p, 32'd2};
                end
                CMF_OP_RELATIVE_JUMP, CMF_OP_RELATIVE_CALL: begin
                    e_pc = m_pc + {{4{rel_offset[11]}}, rel_offset} + 16'h0001;
                    e_push = (op == CMF_OP_RELATIVE_CALL);
                    e_cyc = e_push ? 3 : 2;
                end
                CMF_OP_POINTER_JUMP, CMF_OP_POINTER_CALL: begin
                    e_push = (op == CMF_OP_POINTER_CALL);
                    {e_pc, e_cyc} = {z_ptr, e_push ? 32'd3 : 32'd2};
                end
                CMF_OP_ABSOLUTE_JUMP, CMF_OP_ABSOLUTE_CALL: begin
                    e_push = (op == CMF_OP_ABSOLUTE_CALL);
                    {e_pc, e_cyc} = {abs_addr, e_push ? 32'd4 : 32'd3};
                end
                CMF_OP_SUBROUTINE_RETURN, CMF_OP_INTERRUPT_RETURN:
                    {e_pop, e_pc, e_cyc} = {1'b1, stack_pc, 32'd4};
                CMF_OP_COMPARE, CMF_OP_COMPARE_WITH_CARRY, CMF_OP_COMPARE_IMMEDIATE: begin
                    e_sr[0] = d[8];
                    e_sr[1] = (d[7:0] == 8'h00) && (op != CMF_OP_COMPARE_WITH_CARRY || m_sr[1]);
                    e_sr[2] = d[7];
                    e_sr[3] = (rd_val[7] & ~b[7] & ~d[7]) | (~rd_val[7] & b[7] & d[7]);
                    e_sr[5] = (~rd_val[3] & b[3]) | (b[3] & d[3]) | (d[3] & ~rd_val[3]);
                end
                CMF_OP_COMPARE_SKIP_EQUAL: sk = (rd_val == rr_val);
                CMF_OP_SKIP_REG_BIT_CLEAR: sk = !rr_val[bit_sel];
                CMF_OP_SKIP_REG_BIT_SET: sk = rr_val[bit_sel];
                CMF_OP_SKIP_IO_BIT_CLEAR: sk = !io_val[bit_sel];
                CMF_OP_SKIP_IO_BIT_SET: sk = io_val[bit_sel];
                CMF_OP_BRANCH_FLAG_SET: tk = sel;
                CMF_OP_BRANCH_FLAG_CLEAR: tk = !sel;
                default: e_cyc = 1;
            endcase
            e_sr[7] = e_sr[7] | (op == CMF_OP_INTERRUPT_RETURN); // Interrupt return re-enables interrupts
            if (sk) begin
                e_pc = m_pc + (next_two_word ? 16'h0003 : 16'h0002);
                e_cyc = next_two_word ? 3 : 2;
            end
            if (tk) begin
                e_pc = m_pc + {{9{br_offset[6]}}, br_offset} + 16'h0001;
                e_cyc = 2;
            end
        end
    endfunction

    // ----------------------------------------
    // Drivers and checks
    // ----------------------------------------
    task automatic do_reset(input int n);
        begin
            @(negedge core_clk);
            rst = 1'b1;
            repeat (n) @(negedge core_clk);
            rst = 1'b0;
            m_pc = `CMF_PC_RST;
            m_sr = `CMF_STATUS_REGISTER_RST;
            `CHK("reset pc", `CMF_PC_RST, pc_q)
            `CHK("reset flags", `CMF_STATUS_REGISTER_RST, status_register_q)
            `CHK("reset ready", 1'b1, ready)
            `CHK("reset strobes", 4'h0, {rd_we_q, prod_we_q, push_pc_q, pop_pc_q})
        end
    endtask

    // Issue one instruction; wait for ready under a bound, then compare
    task automatic do_op(input cmf_op_t o, input logic [7:0] a, input logic [7:0] b);
        int n;
        logic pu, po;
        begin
            @(negedge core_clk);
            op = o;
            rd_val = (o inside {CMF_OP_SKIP_REG_BIT_CLEAR, CMF_OP_SKIP_REG_BIT_SET}) ? b : a;
            {rr_val, imm, io_val} = {b, b, b};
            {bit_sel, next_two_word} = 4'($urandom);
            {rel_offset, br_offset} = 19'($urandom);
            {abs_addr, z_ptr} = $urandom;
            stack_pc = 16'($urandom);
            issue = 1'b1;
            #1 predict();
            @(posedge core_clk);
            @(negedge core_clk);
            issue = 1'b0;
            pu = push_pc_q;
            po = pop_pc_q;
            n = 1;
            while (ready !== 1'b1 && n < 8) begin
                @(negedge core_clk);
                n++;
            end
            `CHK("cycles", e_cyc, n)
            `CHK("pc", e_pc, pc_q)
            `CHK("flags", e_sr & 8'hef, status_register_q & 8'hef)
            `CHK("rd write", e_rdwe, rd_we_q)
            if (e_rdwe) `CHK("rd data", e_rdw, rd_wdata_q)
            `CHK("prod write", e_pwe, prod_we_q)
            if (e_pwe) `CHK("product", e_prod, prod_q)
            `CHK("push pop", {e_push, e_pop}, {pu, po})
            m_pc = e_pc;
            m_sr = e_sr;
        end
    endtask

    task automatic wrap_up();
        begin
            $display("Checks made %0d, mismatches %0d", check_count, errors);
            if (errors == 0 && check_count > 0) begin
                $display("TEST PASSED");
            end else begin
                $display("TEST FAILED");
            end
            $finish;
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [15:0] corner [4] = '{16'h8080, 16'hffff, 16'h0037, 16'h0101};
        void'($urandom(32'ha1469e4d));
        repeat (12) @(negedge core_clk);
        do_reset(0);
        // Every code except NOP with sign, zero and overflow corners
        foreach (corner[i]) begin
            for (int k = 1; k <= 28; k++) begin
                do_op(cmf_op_t'(6'(k)), corner[i][15:8], corner[i][7:0]);
            end
        end
        $display("Test directed done");
        // Reset in mid-run must restore the idle state
        do_reset(2);
        $display("Test mid reset done");
        // Random mix; compares feed flags to later branches
        repeat (450) begin
            do_op(cmf_op_t'(6'($urandom_range(1, 28))), 8'($urandom), 8'($urandom));
        end
        $display("Test random done");
        wrap_up();
    end
endmodule
